/* File: indexed_host_access_port.sv */
// indexed host access port: pointers, windows, fifo window, byte order config
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module indexed_host_access_port (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wide_mode,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [4:1] host_addr_hi,
	input wire logic host_location_bit_zero,
	input wire logic [15:0] host_data_in,
	output logic [15:0] host_data_out,
	output logic host_data_oe,
	output logic [15:0] int_addr,
	output logic int_rd_req,
	output logic int_wr_req,
	output logic [31:0] int_wr_data,
	input wire logic [31:0] int_rd_data,
	output logic fifo_wr_valid,
	output logic [31:0] fifo_wr_data,
	output logic fifo_rd_pop,
	input wire logic [31:0] fifo_rd_data,
	output logic writes_enabled
);
	import host_port_pkg::*;

	////////////////////////////////////////////////////////////////
	// decode
	logic [4:0] addr;
	logic [1:0] pair;
	reg_sel_t sel;
	logic rd_act;
	logic wr_act;
	cyc_state_t cyc_r;
	logic [4:0] cap_addr_r;
	logic [15:0] cap_data_r;
	logic rd_end;
	logic wr_end;
	logic [15:0] ptr_r [`HP_NUM_PAIRS];
	logic [3:0] order_r;
	logic armed_r;

	// narrow mode uses the byte address, wide mode forces bit zero low
	assign addr = {host_addr_hi, wide_mode ? 1'b0 : host_location_bit_zero};
	assign rd_act = !cs_n && !rd_n;
	assign wr_act = !cs_n && !wr_n;

	function automatic reg_sel_t decode_sel(input logic [4:0] a);
		reg_sel_t s;
		s = SEL_PTR;
		unique case ({a[4:2], 2'b00})
			`HP_OFS_PTR0, `HP_OFS_PTR1, `HP_OFS_PTR2: s = SEL_PTR;
			`HP_OFS_WIN0, `HP_OFS_WIN1, `HP_OFS_WIN2: s = SEL_WIN;
			`HP_OFS_FIFO: s = SEL_FIFO;
			`HP_OFS_CFG: s = SEL_CFG;
			default: s = SEL_PTR;
		endcase
		return s;
	endfunction

	assign sel = decode_sel(rd_act ? addr : cap_addr_r);
	assign pair = rd_act ? addr[4:3] : cap_addr_r[4:3];

	////////////////////////////////////////////////////////////////
	// cycle tracking: address at leading edge, data at trailing edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cyc_r <= CYC_IDLE;
			cap_addr_r <= 5'h00;
			cap_data_r <= 16'h0000;
		end else begin
			unique case (cyc_r)
				CYC_IDLE: begin
					cap_addr_r <= addr;
					if (rd_act) begin
						cyc_r <= CYC_READ;
					end else if (wr_act) begin
						cyc_r <= CYC_WRITE;
						cap_data_r <= host_data_in;
					end
				end
				CYC_READ: begin
					if (!rd_act) begin
						cyc_r <= CYC_IDLE;
					end
				end
				CYC_WRITE: begin
					cap_data_r <= host_data_in;
					if (!wr_act) begin
						cyc_r <= CYC_IDLE;
					end
				end
			endcase
		end
	end

	assign rd_end = (cyc_r == CYC_READ) && !rd_act;
	assign wr_end = (cyc_r == CYC_WRITE) && !wr_act && armed_r;

	// writes stay ignored until the first completed read
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			armed_r <= 1'b0;
		end else if (rd_end) begin
			armed_r <= 1'b1;
		end
	end
	assign writes_enabled = armed_r;

	////////////////////////////////////////////////////////////////
	// per-channel byte order and lane
	logic [1:0] lane_idx;
	logic chan_big;
	logic [1:0] lane_lo;
	logic [1:0] cfg_byte;
	assign lane_idx = (sel == SEL_FIFO) ? `HP_LANE_IDX_FIFO : pair;
	assign chan_big = (sel == SEL_FIFO) ? order_r[`HP_CFG_FIFO_BIT] : order_r[pair];
	assign lane_lo = rd_act ? addr[1:0] : cap_addr_r[1:0];
	assign cfg_byte = lane_lo;

	// index register write, partial lanes taking effect at once
	genvar gp;
	generate
		for (gp = 0; gp < `HP_NUM_PAIRS; gp++) begin : g_ptr
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					ptr_r[gp] <= `HP_PTR_RESET;
				end else if (wr_end && sel == SEL_PTR && pair == gp) begin
					if (wide_mode) begin
						if (lane_lo[1] ^ order_r[gp]) begin
							// upper half is reserved
						end else begin
							ptr_r[gp] <= cap_data_r;
						end
					end else begin
						unique case (lane_lo ^ {2{order_r[gp]}})
							2'd0: ptr_r[gp][7:0] <= cap_data_r[7:0];
							2'd1: ptr_r[gp][15:8] <= cap_data_r[7:0];
							default: ptr_r[gp] <= ptr_r[gp];
						endcase
					end
				end
			end
		end
	endgenerate

	// config: any copy written sets the bit in all four lanes
	logic [3:0] cfg_wr_val;
	always_comb begin
		if (wide_mode) begin
			cfg_wr_val = cap_data_r[3:0] | cap_data_r[11:8];
		end else begin
			cfg_wr_val = cap_data_r[3:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			order_r <= `HP_CFG_RESET;
		end else if (wr_end && sel == SEL_CFG) begin
			order_r <= cfg_wr_val;
		end
	end

	////////////////////////////////////////////////////////////////
	// data channels: three windows and the fifo window
	logic [15:0] ch_part [4];
	logic [31:0] ch_word [4];
	logic [3:0] ch_wr_done;
	logic [3:0] ch_rd_done;
	logic [3:0] ch_rd_go;
	logic [3:0] ch_wr_go;
	logic data_sel;
	assign data_sel = (sel == SEL_WIN) || (sel == SEL_FIFO);

	genvar gc;
	generate
		for (gc = 0; gc < 4; gc++) begin : g_ch
			assign ch_wr_go[gc] = wr_end && data_sel && lane_idx == gc;
			assign ch_rd_go[gc] = rd_end && data_sel && cap_addr_r[4:3] == gc;
			dword_assembler u_asm (
				.clk(clk),
				.resetn(resetn),
				.wide_mode(wide_mode),
				.big_endian(gc == 3 ? order_r[`HP_CFG_FIFO_BIT] : order_r[gc]),
				.lane_addr(lane_lo),
				.wr_data(cap_data_r),
				.wr_strobe(ch_wr_go[gc]),
				.rd_strobe(ch_rd_go[gc]),
				.rd_word(gc == 3 ? fifo_rd_data : int_rd_data),
				.rd_part(ch_part[gc]),
				.wr_word(ch_word[gc]),
				.wr_done(ch_wr_done[gc]),
				.rd_done(ch_rd_done[gc])
			);
		end
	endgenerate

	// internal address follows the pointer of the active pair
	logic [1:0] wr_pair_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_pair_r <= 2'd0;
		end else if (wr_end && sel == SEL_WIN) begin
			wr_pair_r <= pair;
		end
	end

	always_comb begin
		int_addr = ptr_r[0];
		if (int_wr_req) begin
			if (wr_pair_r < 2'd3) begin
				int_addr = ptr_r[wr_pair_r];
			end
		end else if (pair < 2'd3) begin
			int_addr = ptr_r[pair];
		end
	end

	assign int_wr_req = |ch_wr_done[2:0];
	assign int_rd_req = (cyc_r == CYC_READ) && (sel == SEL_WIN);
	always_comb begin
		int_wr_data = ch_word[0];
		if (ch_wr_done[1]) begin
			int_wr_data = ch_word[1];
		end else if (ch_wr_done[2]) begin
			int_wr_data = ch_word[2];
		end
	end
	assign fifo_wr_valid = ch_wr_done[3];
	assign fifo_wr_data = ch_word[3];
	assign fifo_rd_pop = ch_rd_done[3];

	////////////////////////////////////////////////////////////////
	// read data path, registered
	logic [15:0] rd_val;
	logic [1:0] pl;
	always_comb begin
		pl = lane_lo ^ {2{chan_big}};
		rd_val = 16'h0000;
		unique case (sel)
			SEL_PTR: begin
				if (wide_mode) begin
					rd_val = pl[1] ? 16'h0000 : ptr_r[pair];
				end else begin
					unique case (pl)
						2'd0: rd_val = {8'h00, ptr_r[pair][7:0]};
						2'd1: rd_val = {8'h00, ptr_r[pair][15:8]};
						default: rd_val = 16'h0000;
					endcase
				end
			end
			SEL_WIN, SEL_FIFO: rd_val = ch_part[lane_idx];
			SEL_CFG: begin
				rd_val = {4'h0, order_r, 4'h0, order_r};
				if (!wide_mode) begin
					rd_val[15:8] = 8'h00;
				end
			end
			default: rd_val = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			host_data_out <= 16'h0000;
			host_data_oe <= 1'b0;
		end else begin
			host_data_out <= rd_val;
			host_data_oe <= rd_act;
		end
	end
endmodule

/* File: host_port_cfg.svh */
// constants for the indexed host access port
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH
`define HP_OFS_PTR0 5'h00
`define HP_OFS_WIN0 5'h04
`define HP_OFS_PTR1 5'h08
`define HP_OFS_WIN1 5'h0c
`define HP_OFS_PTR2 5'h10
`define HP_OFS_WIN2 5'h14
`define HP_OFS_FIFO 5'h18
`define HP_OFS_CFG 5'h1c
`define HP_PTR_RESET 16'h1234
`define HP_CFG_RESET 4'h0
`define HP_CFG_FIFO_BIT 3
`define HP_NUM_PAIRS 3
`define HP_LANE_IDX_FIFO 2'd3
`endif

/* File: host_port_pkg.sv */
// types for the indexed host access port
package host_port_pkg;
	typedef enum logic [3:0] {
		SEL_PTR = 4'b0001,
		SEL_WIN = 4'b0010,
		SEL_FIFO = 4'b0100,
		SEL_CFG = 4'b1000
	} reg_sel_t;
	typedef enum logic [2:0] {
		CYC_IDLE = 3'b001,
		CYC_READ = 3'b010,
		CYC_WRITE = 3'b100
	} cyc_state_t;
endpackage

/* File: dword_assembler.sv */
// word/byte to dword conversion for one data channel
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module dword_assembler (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wide_mode,
	input wire logic big_endian,
	input wire logic [1:0] lane_addr,
	input wire logic [15:0] wr_data,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	input wire logic [31:0] rd_word,
	output logic [15:0] rd_part,
	output logic [31:0] wr_word,
	output logic wr_done,
	output logic rd_done
);
	logic [31:0] asm_r;
	logic [1:0] wr_cnt_r;
	logic [1:0] rd_cnt_r;
	logic [1:0] byte_lane;
	logic last_wr;
	logic last_rd;

	// lane mapping: big endian mirrors the lane within the dword
	always_comb begin
		if (wide_mode) begin
			byte_lane = {lane_addr[1] ^ big_endian, 1'b0};
		end else begin
			byte_lane = lane_addr ^ {2{big_endian}};
		end
	end

	assign last_wr = wide_mode ? (wr_cnt_r == 2'd1) : (wr_cnt_r == 2'd3);
	assign last_rd = wide_mode ? (rd_cnt_r == 2'd1) : (rd_cnt_r == 2'd3);

	always_comb begin
		if (wide_mode) begin
			rd_part = byte_lane[1] ? rd_word[31:16] : rd_word[15:0];
		end else begin
			rd_part = {8'h00, rd_word[{byte_lane, 3'b000} +: 8]};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			asm_r <= 32'h0000_0000;
			wr_cnt_r <= 2'd0;
			wr_done <= 1'b0;
			wr_word <= 32'h0000_0000;
		end else begin
			wr_done <= 1'b0;
			if (wr_strobe) begin
				if (wide_mode) begin
					asm_r[{byte_lane[1], 4'b0000} +: 16] <= wr_data;
				end else begin
					asm_r[{byte_lane, 3'b000} +: 8] <= wr_data[7:0];
				end
				if (last_wr) begin
					wr_cnt_r <= 2'd0;
					wr_done <= 1'b1;
					wr_word <= asm_r;
					if (wide_mode) begin
						wr_word[{byte_lane[1], 4'b0000} +: 16] <= wr_data;
					end else begin
						wr_word[{byte_lane, 3'b000} +: 8] <= wr_data[7:0];
					end
				end else begin
					wr_cnt_r <= wr_cnt_r + 2'd1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_cnt_r <= 2'd0;
			rd_done <= 1'b0;
		end else begin
			rd_done <= 1'b0;
			if (rd_strobe) begin
				if (last_rd) begin
					rd_cnt_r <= 2'd0;
					rd_done <= 1'b1;
				end else begin
					rd_cnt_r <= rd_cnt_r + 2'd1;
				end
			end
		end
	end
endmodule

/* File: host_port_chk.sv */
// assertions on the ports of the indexed host access port
`timescale 1ns/1ps
module host_port_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic [4:1] host_addr_hi,
	input wire logic host_data_oe,
	input wire logic int_rd_req,
	input wire logic int_wr_req,
	input wire logic fifo_wr_valid,
	input wire logic fifo_rd_pop,
	input wire logic writes_enabled
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	a_read_drives_bus: assert property (!cs_n && !rd_n |=> host_data_oe)
		else $error("bus not driven during read");
	a_idle_releases_bus: assert property (cs_n || rd_n |=> !host_data_oe)
		else $error("bus driven outside read");
	a_writes_blocked: assert property (!writes_enabled |-> !int_wr_req && !fifo_wr_valid)
		else $error("write passed before first read");
	a_enable_sticky: assert property (writes_enabled |=> writes_enabled)
		else $error("write enable dropped");
	a_enable_needs_read: assert property ((!writes_enabled && rd_n)[*4] |=> !writes_enabled)
		else $error("write enable without read");
	a_wr_single_pulse: assert property (int_wr_req |=> !int_wr_req)
		else $error("internal write pulse too long");
	a_fifo_single_push: assert property (fifo_wr_valid |=> !fifo_wr_valid)
		else $error("fifo push too long");
	a_fifo_single_pop: assert property (fifo_rd_pop |=> !fifo_rd_pop)
		else $error("fifo pop too long");
	a_rd_req_window: assert property (int_rd_req |-> host_addr_hi[2] && host_addr_hi[4:3] != 2'h3)
		else $error("internal read outside window");
endmodule
bind indexed_host_access_port host_port_chk i_chk (.clk(clk), .resetn(resetn), .cs_n(cs_n),
	.rd_n(rd_n), .host_addr_hi(host_addr_hi), .host_data_oe(host_data_oe),
	.int_rd_req(int_rd_req), .int_wr_req(int_wr_req), .fifo_wr_valid(fifo_wr_valid),
	.fifo_rd_pop(fifo_rd_pop), .writes_enabled(writes_enabled));

/* File: internal_space_model.sv */
// model of internal registers and process memory fifos
`timescale 1ns/1ps
module internal_space_model (
	input wire logic clk,
	input wire logic [15:0] int_addr,
	input wire logic int_rd_req,
	input wire logic int_wr_req,
	input wire logic [31:0] int_wr_data,
	output logic [31:0] int_rd_data,
	input wire logic fifo_wr_valid,
	input wire logic [31:0] fifo_wr_data,
	input wire logic fifo_rd_pop,
	output logic [31:0] fifo_rd_data
);
	logic [31:0] mem [logic [15:0]];
	logic [31:0] fifo_last = 32'h0;
	int pops = 0;
	// idle read data toggles so stale values never match
	assign int_rd_data = int_rd_req ? mem[int_addr] : {16{clk, ~clk}};
	assign fifo_rd_data = 32'h8877_6655 + pops;
	always @(posedge clk) begin
		if (int_wr_req)
			mem[int_addr] = int_wr_data;
		if (fifo_wr_valid)
			fifo_last = fifo_wr_data;
		if (fifo_rd_pop)
			pops++;
	end
endmodule

/* File: indexed_host_access_port_bench.sv */
// self-checking bench for the indexed host access port
`timescale 1ns/1ps
module indexed_host_access_port_bench;
	logic clk = 0;
	logic resetn = 0;
	logic wide_mode = 0;
	logic cs_n = 1;
	logic rd_n = 1;
	logic wr_n = 1;
	logic [4:1] host_addr_hi = 4'h0;
	logic host_location_bit_zero = 0;
	logic [15:0] host_data_in = 16'h0;
	logic [15:0] host_data_out, int_addr;
	logic host_data_oe, int_rd_req, int_wr_req, fifo_wr_valid, fifo_rd_pop, writes_enabled;
	logic [31:0] int_wr_data, int_rd_data, fifo_wr_data, fifo_rd_data;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	always #2 clk = ~clk;
	indexed_host_access_port i_dut (.clk(clk), .resetn(resetn), .wide_mode(wide_mode),
		.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .host_addr_hi(host_addr_hi),
		.host_location_bit_zero(host_location_bit_zero), .host_data_in(host_data_in),
		.host_data_out(host_data_out), .host_data_oe(host_data_oe), .int_addr(int_addr),
		.int_rd_req(int_rd_req), .int_wr_req(int_wr_req), .int_wr_data(int_wr_data),
		.int_rd_data(int_rd_data), .fifo_wr_valid(fifo_wr_valid), .fifo_wr_data(fifo_wr_data),
		.fifo_rd_pop(fifo_rd_pop), .fifo_rd_data(fifo_rd_data), .writes_enabled(writes_enabled));
	internal_space_model p (.clk(clk), .int_addr(int_addr), .int_rd_req(int_rd_req),
		.int_wr_req(int_wr_req), .int_wr_data(int_wr_data), .int_rd_data(int_rd_data),
		.fifo_wr_valid(fifo_wr_valid), .fifo_wr_data(fifo_wr_data),
		.fifo_rd_pop(fifo_rd_pop), .fifo_rd_data(fifo_rd_data));
	////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic hw(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		{host_addr_hi, host_location_bit_zero} = a;
		host_data_in = d;
		cs_n = 0;
		wr_n = 0;
		repeat (2) @(posedge clk);
		#1;
		cs_n = 1;
		wr_n = 1;
		repeat (2) @(posedge clk);
	endtask
	// read one part and compare it
	task automatic rc(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk);
		#1;
		{host_addr_hi, host_location_bit_zero} = a;
		cs_n = 0;
		rd_n = 0;
		repeat (2) @(posedge clk);
		#1;
		cmp($sformatf("read %h", a), {16'h0, e}, {16'h0, host_data_out});
		cs_n = 1;
		rd_n = 1;
		repeat (2) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			print_verdict;
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		#1;
		resetn = 1;
		hw(5'h00, 16'h77);
		cmp("enable", 32'h0, {31'h0, writes_enabled});
		for (int i = 0; i < 4; i++)
			rc(5'(i), {8'h00, 8'(32'h1234 >> (8 * i))});
		cmp("enable", 32'h1, {31'h0, writes_enabled});
		hw(5'h08, 16'h56);
		rc(5'h08, 16'h56);
		rc(5'h00, 16'h34);
		hw(5'h02, 16'hff);
		rc(5'h02, 16'h00);
		hw(5'h1d, 16'h01);
		rc(5'h1c, 16'h01);
		rc(5'h00, 16'h00);
		rc(5'h03, 16'h34);
		hw(5'h1f, 16'h08);
		rc(5'h1e, 16'h08);
		hw(5'h1c, 16'h00);
		rc(5'h00, 16'h34);
		hw(5'h00, 16'h40);
		hw(5'h01, 16'h00);
		for (int i = 0; i < 4; i++)
			hw(5'h04 + 5'(i), 16'ha0 + 16'(i));
		repeat (2) @(posedge clk);
		cmp("mem 40", 32'ha3a2a1a0, p.mem[16'h40]);
		for (int i = 0; i < 4; i++)
			rc(5'h07 - 5'(i), 16'ha3 - 16'(i));
		for (int i = 0; i < 4; i++)
			hw(5'h18 + 5'(i), 16'hc0 + 16'(i));
		repeat (2) @(posedge clk);
		cmp("fifo wr", 32'hc3c2c1c0, p.fifo_last);
		for (int i = 0; i < 4; i++)
			rc(5'h18 + 5'(i), 16'h55 + 16'(i * 32'h11));
		repeat (2) @(posedge clk);
		cmp("pops", 32'h1, 32'(p.pops));
		wide_mode = 1;
		rc(5'h01, 16'h0040);
		hw(5'h08, 16'hbeef);
		rc(5'h08, 16'hbeef);
		print_verdict;
	end
endmodule
